// ==== rtl/divide_pkg.sv ====
/*
 divide_pkg: shared widths, command codes, operand selects, register ids and
 sequencer states for the divide step datapath and its sequencer.
 assumes: both ends are compiled against this package.
*/
package divide_pkg;
    localparam int WORD_W = 16;
    localparam int CNT_W = 5;
    localparam logic [15:0] WORD_RST = 16'h0000;
    localparam logic [4:0] UNSIGNED_STEPS = 5'h10;
    localparam logic [4:0] SIGNED_TAIL_STEPS = 5'h0F;
    localparam int AQ_BIT = 6;
    localparam int SIGN_BIT = 15;

    typedef enum logic [2:0] {
        OP_NOP = 3'h0,
        OP_LOAD = 3'h1,
        OP_CLR_AQ = 3'h2,
        OP_DIVS = 3'h3,
        OP_DIVQ = 3'h4,
        OP_ADD = 3'h5
    } step_op_t;

    typedef enum logic [2:0] {
        XS_AX0 = 3'h0,
        XS_AX1 = 3'h1,
        XS_AR = 3'h2,
        XS_MR_LOW = 3'h3,
        XS_MR_MID = 3'h4,
        XS_MR_HIGH = 3'h5,
        XS_SR_LOW = 3'h6,
        XS_SR_HIGH = 3'h7
    } x_sel_t;

    typedef enum logic [1:0] {
        YS_AY0 = 2'h0,
        YS_AY1 = 2'h1,
        YS_AF = 2'h2,
        YS_ZERO = 2'h3
    } y_sel_t;

    localparam logic Z_RESULT = 1'b0;
    localparam logic Z_FEEDBACK = 1'b1;

    typedef enum logic [2:0] {
        RG_AX0 = 3'h0,
        RG_AX1 = 3'h1,
        RG_AY0 = 3'h2,
        RG_AY1 = 3'h3,
        RG_AF = 3'h4,
        RG_AR = 3'h5
    } load_reg_t;

    typedef enum logic [7:0] {
        ST_IDLE = 8'h01,
        ST_LOAD_X = 8'h02,
        ST_LOAD_LOW = 8'h04,
        ST_LOAD_UP = 8'h08,
        ST_FIRST = 8'h10,
        ST_STEPS = 8'h20,
        ST_SETTLE = 8'h40,
        ST_DONE = 8'h80
    } seq_state_t;
endpackage : divide_pkg

// ==== rtl/divide_link.sv ====
/*
 divide_link: step command path from sequencer to divide datapath and the
 datapath's registered words back.
 assumes: one clock; one command per cycle, acted on at the next edge.
*/
`timescale 1ns/1ps
`default_nettype none
interface divide_link;
    import divide_pkg::*;
    step_op_t op;
    x_sel_t x_sel;
    y_sel_t y_sel;
    logic z_sel;
    load_reg_t ld_reg;
    logic [15:0] ld_data;
    logic [15:0] low_word;
    logic [15:0] feedback_word;
    logic [15:0] result_word;
    logic aq;

    modport alu_end (
        input op,
        input x_sel,
        input y_sel,
        input z_sel,
        input ld_reg,
        input ld_data,
        output low_word,
        output feedback_word,
        output result_word,
        output aq
    );

    modport seq_end (
        output op,
        output x_sel,
        output y_sel,
        output z_sel,
        output ld_reg,
        output ld_data,
        input low_word,
        input feedback_word,
        input result_word,
        input aq
    );
endinterface : divide_link
`default_nettype wire

// ==== rtl/divide_step_unit.sv ====
/*
 divide_step_unit: ALU divide datapath with signed first step, quotient step,
 register loads and a plain add routed by the destination select.
 assumes: commands arrive from the sequencer on ref_clk; MAC and shifter
 result words come from neighbouring units on the same clock.
*/
`timescale 1ns/1ps
`default_nettype none

module divide_step_unit
    import divide_pkg::*;
(
    input wire logic ref_clk,
    input wire logic nrst,
    divide_link.alu_end link,
    input wire logic [15:0] mac_result_low,
    input wire logic [15:0] mac_result_mid,
    input wire logic [15:0] mac_result_high,
    input wire logic [15:0] shifter_result_low,
    input wire logic [15:0] shifter_result_high,
    output logic quotient_bit_flag,
    output logic [15:0] arith_status_word
);
    logic [15:0] alu_x_input_0;
    logic [15:0] alu_x_input_1;
    logic [15:0] alu_y_input_0;
    logic [15:0] alu_y_input_1;
    logic [15:0] alu_feedback_reg;
    logic [15:0] alu_result_reg;

    logic [15:0] next_x0;
    logic [15:0] next_x1;
    logic [15:0] next_y0;
    logic [15:0] next_y1;
    logic [15:0] next_af;
    logic [15:0] next_ar;
    logic next_aq;

    wire [15:0] x_operand;
    wire [15:0] y_operand;
    wire [15:0] step_sum;
    wire [15:0] plain_sum;
    wire step_flag;
    wire first_sign;
    wire is_load;
    wire is_divs;
    wire is_divq;
    wire is_add;

    function automatic logic loads(input load_reg_t want, input load_reg_t got, input logic ld);
        loads = ld && (got == want);
    endfunction : loads

    assign is_load = (link.op == OP_LOAD);
    assign is_divs = (link.op == OP_DIVS);
    assign is_divq = (link.op == OP_DIVQ);
    assign is_add = (link.op == OP_ADD);

    // X operand decode
    assign x_operand = (link.x_sel == XS_AX0) ? alu_x_input_0 :
                       (link.x_sel == XS_AX1) ? alu_x_input_1 :
                       (link.x_sel == XS_AR) ? alu_result_reg :
                       (link.x_sel == XS_MR_LOW) ? mac_result_low :
                       (link.x_sel == XS_MR_MID) ? mac_result_mid :
                       (link.x_sel == XS_MR_HIGH) ? mac_result_high :
                       (link.x_sel == XS_SR_LOW) ? shifter_result_low :
                       shifter_result_high;

    // Y operand decode, the last code gives zero
    assign y_operand = (link.y_sel == YS_AY0) ? alu_y_input_0 :
                       (link.y_sel == YS_AY1) ? alu_y_input_1 :
                       (link.y_sel == YS_AF) ? alu_feedback_reg :
                       WORD_RST;

    // quotient step: flag low subtracts, flag high adds; the partial
    // remainder always sits in feedback, whatever the Y select says
    assign step_sum = quotient_bit_flag ? alu_feedback_reg + x_operand
                                        : alu_feedback_reg - x_operand;
    assign step_flag = x_operand[SIGN_BIT] ^ step_sum[SIGN_BIT];

    // signed first step: sign of the quotient from both operand signs;
    // the upper word comes through the Y select (Y1 or feedback)
    assign first_sign = y_operand[SIGN_BIT] ^ x_operand[SIGN_BIT];

    assign plain_sum = x_operand + y_operand;

    assign next_x0 = loads(RG_AX0, link.ld_reg, is_load) ? link.ld_data : alu_x_input_0;
    assign next_x1 = loads(RG_AX1, link.ld_reg, is_load) ? link.ld_data : alu_x_input_1;
    assign next_y1 = loads(RG_AY1, link.ld_reg, is_load) ? link.ld_data : alu_y_input_1;

    // low word takes the shifted dividend; the quotient grows in its lsbs
    assign next_y0 = loads(RG_AY0, link.ld_reg, is_load) ? link.ld_data :
                     is_divs ? {alu_y_input_0[14:0], first_sign} :
                     is_divq ? {alu_y_input_0[14:0], ~step_flag} :
                     alu_y_input_0;

    // feedback takes the upper half of the shifted 32-bit pair
    assign next_af = loads(RG_AF, link.ld_reg, is_load) ? link.ld_data :
                     is_divs ? {y_operand[14:0], alu_y_input_0[SIGN_BIT]} :
                     is_divq ? {step_sum[14:0], alu_y_input_0[SIGN_BIT]} :
                     (is_add && link.z_sel == Z_FEEDBACK) ? plain_sum :
                     alu_feedback_reg;

    assign next_ar = loads(RG_AR, link.ld_reg, is_load) ? link.ld_data :
                     (is_add && link.z_sel == Z_RESULT) ? plain_sum :
                     alu_result_reg;

    // the flag steers the next step's add or subtract; the signed step
    // seeds it so the first quotient step after it picks correctly
    assign next_aq = (link.op == OP_CLR_AQ) ? 1'b0 :
                     is_divs ? first_sign :
                     is_divq ? step_flag :
                     quotient_bit_flag;

    // one step per edge: sixteen edges produce the full quotient, whose
    // binary point follows from the operand formats alone
    always_ff @(posedge ref_clk or negedge nrst)
    begin
        if (!nrst)
            alu_y_input_0 <= WORD_RST;
        else
            alu_y_input_0 <= next_y0;
    end

    always_ff @(posedge ref_clk or negedge nrst)
    begin
        if (!nrst)
            alu_feedback_reg <= WORD_RST;
        else
            alu_feedback_reg <= next_af;
    end

    always_ff @(posedge ref_clk or negedge nrst)
    begin
        if (!nrst)
            quotient_bit_flag <= 1'b0;
        else
            quotient_bit_flag <= next_aq;
    end

    // operand registers change only on loads; the result register also on a plain add
    always_ff @(posedge ref_clk or negedge nrst)
    begin
        if (!nrst)
            alu_x_input_0 <= WORD_RST;
        else
            alu_x_input_0 <= next_x0;
    end

    always_ff @(posedge ref_clk or negedge nrst)
    begin
        if (!nrst)
            alu_x_input_1 <= WORD_RST;
        else
            alu_x_input_1 <= next_x1;
    end

    always_ff @(posedge ref_clk or negedge nrst)
    begin
        if (!nrst)
            alu_y_input_1 <= WORD_RST;
        else
            alu_y_input_1 <= next_y1;
    end

    always_ff @(posedge ref_clk or negedge nrst)
    begin
        if (!nrst)
            alu_result_reg <= WORD_RST;
        else
            alu_result_reg <= next_ar;
    end

    // status word carries only the quotient bit here; other flags live
    // in the rest of the ALU
    always_comb
    begin
        arith_status_word = WORD_RST;
        arith_status_word[AQ_BIT] = quotient_bit_flag;
    end

    assign link.low_word = alu_y_input_0;
    assign link.feedback_word = alu_feedback_reg;
    assign link.result_word = alu_result_reg;
    assign link.aq = quotient_bit_flag;
endmodule : divide_step_unit
`default_nettype wire

// ==== rtl/divide_sequencer.sv ====
/*
 divide_sequencer: issues the load and step commands of one whole division.
 assumes: the divide_step_unit on the far side of divide_link runs on the
 same ref_clk and acts on each command at the next edge.
*/
`timescale 1ns/1ps
`default_nettype none
module divide_sequencer
    import divide_pkg::*;
(
    input wire logic ref_clk,
    input wire logic nrst,
    divide_link.seq_end link,
    input wire logic start,
    input wire logic signed_mode,
    input wire logic int_mode,
    input wire logic [31:0] dividend,
    input wire logic [15:0] divisor,
    output logic busy,
    output logic done,
    output logic overflow,
    output logic [15:0] quotient,
    output logic [15:0] remainder
);
    seq_state_t state;
    seq_state_t next_state;
    logic [31:0] num;
    logic [15:0] den;
    logic is_signed;
    logic [4:0] steps_left;
    wire [31:0] shaped;
    wire too_big;
    wire last_step;

    function automatic logic [15:0] mag(input logic [15:0] v, input logic sgn);
        mag = (sgn && v[SIGN_BIT]) ? 16'(-v) : v;
    endfunction : mag

    // integer operands are moved to 31.1 so the quotient lands in 16.0
    assign shaped = int_mode ? {dividend[30:0], 1'b0} : dividend;
    // screen for overflow; a set divisor msb breaks unsigned division
    assign too_big = (mag(shaped[31:16], signed_mode) > mag(divisor, signed_mode))
                     || (!signed_mode && divisor[SIGN_BIT]);
    assign last_step = (steps_left == 5'h01);

    always_comb
    begin
        next_state = state;
        case (state)
            ST_IDLE: if (start) next_state = too_big ? ST_DONE : ST_LOAD_X;
            ST_LOAD_X: next_state = ST_LOAD_LOW;
            ST_LOAD_LOW: next_state = ST_LOAD_UP;
            ST_LOAD_UP: next_state = ST_FIRST;
            ST_FIRST: next_state = ST_STEPS;
            ST_STEPS: if (last_step) next_state = ST_SETTLE;
            ST_SETTLE: next_state = ST_DONE;
            ST_DONE: next_state = ST_IDLE;
            default: next_state = ST_IDLE;
        endcase
    end

    always_comb
    begin
        link.op = OP_NOP;
        link.x_sel = XS_AX0; // divisor always kept in X input 0
        link.y_sel = YS_AY0;
        link.z_sel = Z_RESULT;
        link.ld_reg = RG_AX0;
        link.ld_data = den;
        case (state)
            ST_LOAD_X: link.op = OP_LOAD;
            ST_LOAD_LOW:
            begin
                link.op = OP_LOAD;
                link.ld_reg = RG_AY0;
                link.ld_data = num[15:0];
            end
            ST_LOAD_UP:
            begin
                link.op = OP_LOAD;
                link.ld_reg = is_signed ? RG_AY1 : RG_AF;
                link.ld_data = num[31:16];
            end
            ST_FIRST:
            begin
                // signed starts with the signed step; unsigned clears the flag
                // and lets its first quotient step come from ST_STEPS
                link.op = is_signed ? OP_DIVS : OP_CLR_AQ;
                link.y_sel = YS_AY1;
            end
            ST_STEPS:
            begin
                link.op = OP_DIVQ;
                link.y_sel = YS_AF;
            end
            default: link.op = OP_NOP;
        endcase
    end

    always_ff @(posedge ref_clk or negedge nrst)
    begin
        if (!nrst)
        begin
            state <= ST_IDLE;
            num <= 32'h00000000;
            den <= WORD_RST;
            is_signed <= 1'b0;
            steps_left <= 5'h00;
            overflow <= 1'b0;
            quotient <= WORD_RST;
            remainder <= WORD_RST;
        end
        else
        begin
            state <= next_state;
            if (state == ST_IDLE && start)
            begin
                num <= shaped;
                den <= divisor;
                // one signedness for both operands and the quotient
                is_signed <= signed_mode;
                overflow <= too_big;
                steps_left <= signed_mode ? SIGNED_TAIL_STEPS : UNSIGNED_STEPS;
            end
            if (state == ST_STEPS)
            begin
                steps_left <= steps_left - 5'h01;
            end
            if (state == ST_SETTLE)
            begin
                quotient <= link.low_word;
                // non-restoring leaves the remainder short by twice the
                // divisor after a zero last bit
                remainder <= link.low_word[0] ? link.feedback_word
                                              : 16'(link.feedback_word + {den[14:0], 1'b0});
            end
        end
    end

    assign busy = (state != ST_IDLE);
    assign done = (state == ST_DONE);
endmodule : divide_sequencer
`default_nettype wire

// ==== tb/divide_step_unit_sva.sv ====
/*
 divide_step_unit_sva: assertions on the step command link between sequencer
 and divide datapath.
 assumes: instantiated beside divide_link, one clock, divisor kept in AX0.
*/
`timescale 1ns/1ps
`default_nettype none
module divide_step_unit_sva
    import divide_pkg::*;
(
    input wire logic ref_clk,
    input wire logic nrst,
    input wire step_op_t op,
    input wire y_sel_t y_sel,
    input wire load_reg_t ld_reg,
    input wire logic [15:0] ld_data,
    input wire logic [15:0] low_word,
    input wire logic [15:0] feedback_word,
    input wire logic aq
);
    logic [15:0] ax0;
    logic [15:0] ay1;
    logic [4:0] run;
    logic sgn;
    wire logic [15:0] rem;
    wire logic [15:0] upper;
    wire logic [4:0] limit;

    // shadows of loads the datapath keeps hidden, plus the quotient step run count and the signed-step flag
    always_ff @(posedge ref_clk or negedge nrst)
    begin
        if (!nrst)
        begin
            ax0 <= 16'h0000;
            ay1 <= 16'h0000;
            run <= 5'h00;
            sgn <= 1'b0;
        end
        else
        begin
            ax0 <= (op == OP_LOAD && ld_reg == RG_AX0) ? ld_data : ax0;
            ay1 <= (op == OP_LOAD && ld_reg == RG_AY1) ? ld_data : ay1;
            run <= (op == OP_DIVQ) ? run + 5'h01 : 5'h00;
            sgn <= (op == OP_DIVS) ? 1'b1 : ((op == OP_CLR_AQ) ? 1'b0 : sgn);
        end
    end

    assign rem = aq ? feedback_word + ax0 : feedback_word - ax0;
    assign upper = (y_sel == YS_AF) ? feedback_word : ay1;
    assign limit = sgn ? SIGNED_TAIL_STEPS : UNSIGNED_STEPS;

    default clocking cb @(posedge ref_clk);
    endclocking
    default disable iff (!nrst);

    sequence seq_clear;
        op == OP_LOAD && ld_reg == RG_AF ##1 op == OP_CLR_AQ;
    endsequence

    divq_addsub_a: assert property (
        op == OP_DIVQ |=> feedback_word[15:1] == $past(rem[14:0]))
        else $error("partial remainder wrong after quotient step");
    divq_flag_a: assert property (
        op == OP_DIVQ |=> aq == ($past(ax0[15]) ^ $past(rem[15])))
        else $error("quotient flag wrong after quotient step");
    divq_shift_a: assert property (
        op == OP_DIVQ |=> low_word == {$past(low_word[14:0]), ~aq}
            && feedback_word[0] == $past(low_word[15]))
        else $error("shift wrong after quotient step");
    divs_sign_a: assert property (
        op == OP_DIVS |=> aq == $past(upper[15] ^ ax0[15]))
        else $error("sign wrong after signed step");
    divs_shift_a: assert property (
        op == OP_DIVS |=> low_word == {$past(low_word[14:0]), aq}
            && feedback_word == {$past(upper[14:0]), $past(low_word[15])})
        else $error("shift wrong after signed step");
    clear_flag_a: assert property (
        op == OP_CLR_AQ |=> !aq)
        else $error("flag not cleared");
    unsigned_run_a: assert property (
        seq_clear |=> op == OP_DIVQ [*8])
        else $error("unsigned run does not follow flag clear");
    run_length_a: assert property (
        op != OP_DIVQ && run != 5'h00 |-> run == limit)
        else $error("quotient step run has wrong length");
    run_cap_a: assert property (
        op == OP_DIVQ |-> run < limit)
        else $error("too many quotient steps");
    divs_upper_a: assert property (
        op == OP_DIVS |-> y_sel == YS_AY1 || y_sel == YS_AF)
        else $error("signed step upper word select illegal");
endmodule : divide_step_unit_sva
`default_nettype wire

// ==== tb/test_divide_step_unit.sv ====
/*
 test_divide_step_unit: sequencer and datapath joined by divide_link, plus a
 second datapath driven command by command for the operand selects.
 assumes: divide_pkg compiled first; 250 MHz ref_clk.
*/
`timescale 1ns/1ps
`default_nettype none
`define CHECK(what, exp, got) \
    begin n_tests++; if ((got) !== (exp)) begin miscompares++; \
    $display("ERROR %s expected %h seen %h", what, exp, got); end end
module test_divide_step_unit;
    import divide_pkg::*;
    logic ref_clk, nrst, start, signed_mode, int_mode, flag_a;
    logic busy, done, overflow;
    logic [31:0] dividend;
    logic [15:0] divisor, quotient, remainder, status_a;
    logic [15:0] src [8] = '{16'h0001, 16'h0010, 16'h0100, 16'h1000,
        16'h2000, 16'h3000, 16'h4000, 16'h5000};
    logic [15:0] ldv [6] = '{16'h0001, 16'h0010, 16'h0002, 16'h0020, 16'h0200, 16'h0100};
    logic [15:0] yv [4] = '{16'h0002, 16'h0020, 16'h5000, 16'h0000};
    logic [49:0] vec [8] = '{{2'b01, 32'h0001_86A0, 16'h0007},
        {2'b00, 32'h3FFF_0000, 16'h7FFF}, {2'b00, 32'h0001_0000, 16'h8001},
        {2'b00, 32'h0005_0000, 16'h0004}, {2'b10, 32'hE000_0000, 16'h4000},
        {2'b10, 32'h2000_0000, 16'hC000}, {2'b11, 32'hFFFF_FF9C, 16'h0007},
        {2'b10, 32'h5000_0000, 16'h4000}};
    logic [31:0] last_qr = 32'h0000_0000;
    int miscompares = 0;
    int n_tests = 0;
    int cycles = 0;
    int k;
    divide_link link_a ();
    divide_link link_b ();

    divide_step_unit i_divide_step_unit (.ref_clk(ref_clk), .nrst(nrst), .link(link_a),
        .mac_result_low(src[3]), .mac_result_mid(src[4]), .mac_result_high(src[5]),
        .shifter_result_low(src[6]), .shifter_result_high(src[7]),
        .quotient_bit_flag(flag_a), .arith_status_word(status_a));
    divide_step_unit i_divide_step_unit_b (.ref_clk(ref_clk), .nrst(nrst), .link(link_b),
        .mac_result_low(src[3]), .mac_result_mid(src[4]), .mac_result_high(src[5]),
        .shifter_result_low(src[6]), .shifter_result_high(src[7]),
        .quotient_bit_flag(), .arith_status_word());
    divide_sequencer i_divide_sequencer (.ref_clk(ref_clk), .nrst(nrst), .link(link_a),
        .start(start), .signed_mode(signed_mode), .int_mode(int_mode),
        .dividend(dividend), .divisor(divisor), .busy(busy), .done(done),
        .overflow(overflow), .quotient(quotient), .remainder(remainder));
    divide_step_unit_sva i_divide_step_unit_sva (.ref_clk(ref_clk), .nrst(nrst),
        .op(link_a.op), .y_sel(link_a.y_sel), .ld_reg(link_a.ld_reg),
        .ld_data(link_a.ld_data), .low_word(link_a.low_word),
        .feedback_word(link_a.feedback_word), .aq(link_a.aq));

    task tick;
        @(posedge ref_clk);
        #1;
    endtask : tick

    task print_verdict;
        if (miscompares == 0 && n_tests > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask : print_verdict

    task automatic cmd(input step_op_t o, input int x, input int y, input logic z,
        input load_reg_t r, input logic [15:0] d);
        link_b.op = o;
        link_b.x_sel = x_sel_t'(x);
        link_b.y_sel = y_sel_t'(y);
        link_b.z_sel = z;
        link_b.ld_reg = r;
        link_b.ld_data = d;
        tick();
    endtask : cmd

    // independent step model; remainder gets the raw non-restoring fix-up
    function automatic logic [31:0] model(input logic s, input logic [31:0] dv,
        input logic [15:0] d);
        logic [15:0] fb, lo, r;
        logic q;
        fb = dv[31:16];
        lo = dv[15:0];
        q = s & (fb[15] ^ d[15]);
        if (s)
        begin
            fb = {fb[14:0], lo[15]};
            lo = {lo[14:0], q};
        end
        for (int j = int'(s); j < 16; j++)
        begin
            r = q ? fb + d : fb - d;
            q = d[15] ^ r[15];
            fb = {r[14:0], lo[15]};
            lo = {lo[14:0], ~q};
        end
        return {lo, lo[0] ? fb : fb + {d[14:0], 1'b0}};
    endfunction : model

    function automatic logic too_big(input logic s, input logic [15:0] up,
        input logic [15:0] d);
        logic [15:0] mu, md;
        mu = (s && up[15]) ? -up : up;
        md = (s && d[15]) ? -d : d;
        return (mu > md) || (!s && d[15]);
    endfunction : too_big

    task automatic run_div(input logic s, input logic i, input logic [31:0] dv,
        input logic [15:0] d, input logic poke);
        logic [31:0] eff;
        logic ov;
        int n;
        eff = i ? {dv[30:0], 1'b0} : dv;
        ov = too_big(s, eff[31:16], d);
        tick();
        `CHECK("idle busy", 1'b0, busy);
        start = 1'b1;
        signed_mode = s;
        int_mode = i;
        dividend = dv;
        divisor = d;
        tick();
        start = 1'b0;
        n = 1;
        // a start while busy must leave the running division alone
        while (done !== 1'b1 && n < 40)
        begin
            tick();
            n++;
            start = poke && n == 5;
            dividend = (poke && n == 5) ? ~dv : dv;
        end
        last_qr = ov ? last_qr : model(s, eff, d);
        `CHECK("latency", ov ? 1 : (s ? 21 : 22), n);
        `CHECK("busy at done", 1'b1, busy);
        `CHECK("overflow", ov, overflow);
        `CHECK("quotient", last_qr[31:16], quotient);
        `CHECK("remainder", last_qr[15:0], remainder);
        if (!ov)
            `CHECK("status", {9'h000, ~last_qr[16], 6'h00}, status_a);
        if (!s && i && !ov)
            `CHECK("integer quotient", 16'(dv / {16'h0000, d}), quotient);
    endtask : run_div

    initial
    begin
        ref_clk = 1'b0;
        forever #2 ref_clk = ~ref_clk;
    end

    always @(posedge ref_clk)
    begin
        cycles <= cycles + 1;
        if (cycles == 1000)
        begin
            miscompares++;
            print_verdict();
        end
    end

    initial
    begin
        nrst = 1'b0;
        start = 1'b0;
        signed_mode = 1'b0;
        int_mode = 1'b0;
        dividend = 32'h0000_0000;
        divisor = 16'h0000;
        cmd(OP_NOP, 0, 0, Z_RESULT, RG_AX0, 16'h0000);
        repeat (2) tick();
        nrst = 1'b1;
        `CHECK("flag after reset", 1'b0, flag_a);
        `CHECK("status after reset", 16'h0000, status_a);
        for (k = 0; k < 6; k++)
            cmd(OP_LOAD, 0, 0, Z_RESULT, load_reg_t'(k), ldv[k]);
        for (k = 0; k < 8; k++)
        begin
            cmd(OP_ADD, k, YS_ZERO, Z_FEEDBACK, RG_AX0, 16'h0000);
            `CHECK("x select", src[k], link_b.feedback_word);
        end
        for (k = 0; k < 4; k++)
        begin
            cmd(OP_ADD, XS_AX0, k, Z_RESULT, RG_AX0, 16'h0000);
            `CHECK("y select", 16'h0001 + yv[k], link_b.result_word);
        end
        cmd(OP_ADD, XS_AX0, YS_AY0, Z_FEEDBACK, RG_AX0, 16'h0000);
        `CHECK("feedback dest", 16'h0003, link_b.feedback_word);
        `CHECK("result kept", 16'h0001, link_b.result_word);
        cmd(OP_NOP, 0, 0, Z_RESULT, RG_AX0, 16'h0000);
        for (k = 0; k < 8; k++)
            run_div(vec[k][49], vec[k][48], vec[k][47:16], vec[k][15:0], k == 0);
        print_verdict();
    end
endmodule : test_divide_step_unit
`default_nettype wire
